// file: logic/sdtc_top.sv
// Functional notes
// - Area2 reserved bits read zero, write zero.
// - Area2 bit 10 always reads one.
// - Area2 latency code 01=2, 10=3 cycles.
// - Area3 latency code 01=2, 10=3 cycles.
// - Precharge to activate spacing 1..4 cycles.
// - Activate to access spacing 1..4 cycles.
// - Shared spacing fields serve both areas.
// - Area3 reserved bits read zero, write zero.
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
module sdtc_top
  import sdtc_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [11:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [1:0]       o_area2_latency,
  output logic [1:0]       o_area3_latency,
  output logic [1:0]       o_precharge_to_activate,
  output logic [1:0]       o_activate_to_access
);

  sdtc_cfg_if cfg_bus ();

  logic [1:0]  area2_lat_ff;
  logic [1:0]  area3_lat_ff;
  logic [1:0]  rp_ff;
  logic [1:0]  rcd_ff;
  logic        wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic [1:0]  cmd_ff;
  logic        cmd_area3_ff;
  logic        cmd_ok_ff;
  logic        rstrobe_ff;
  logic [7:0]  refused_cnt_ff;
  logic [1:0]  o_lat2_ff;
  logic [1:0]  o_lat3_ff;
  logic [1:0]  o_rp_ff;
  logic [1:0]  o_rcd_ff;
  logic        addr_valid;
  logic        rd_req;
  logic        wr_req;
  logic [31:0] area2_view;
  logic [31:0] area3_view;
  logic [31:0] status_view;
  logic [31:0] nxt_hrdata;
  logic        cmd_ok;
  logic        rdata_strobe;
  sdtc_cmd_t   cmd_now;

  // Address phase decode.
  assign addr_valid = i_hsel && i_hready && i_htrans[1];
  assign rd_req     = addr_valid && !i_hwrite;
  assign wr_req     = addr_valid && i_hwrite;

  // Read views: fixed one at area2 bit 10, reserved bits zero.
  assign area2_view = (32'h1 << SDTC_FIXED_ONE)
                    | ({30'h0, area2_lat_ff} << SDTC_LAT_LSB);
  assign area3_view = ({30'h0, rp_ff} << SDTC_RP_LSB)
                    | ({30'h0, rcd_ff} << SDTC_RCD_LSB)
                    | ({30'h0, area3_lat_ff} << SDTC_LAT_LSB);
  assign status_view = {22'h0, refused_cnt_ff, cmd_ok_ff, rstrobe_ff};

  // Read mux; unmapped offsets read zero.
  assign nxt_hrdata = (i_haddr == SDTC_OFS_AREA2)  ? area2_view :
                      (i_haddr == SDTC_OFS_AREA3)  ? area3_view :
                      (i_haddr == SDTC_OFS_STATUS) ? status_view : 32'h0;

  assign cmd_now = sdtc_cmd_t'(cmd_ff);

  // Configuration carried to the spacing engine.
  assign cfg_bus.area2_latency         = area2_lat_ff;
  assign cfg_bus.area3_latency         = area3_lat_ff;
  assign cfg_bus.precharge_to_activate = rp_ff;
  assign cfg_bus.activate_to_access    = rcd_ff;

  sdtc_spacing u_spacing (
    .i_core_clk     (i_core_clk),
    .i_rst_n        (i_rst_n),
    .cfg            (cfg_bus),
    .i_cmd          (cmd_now),
    .i_area3        (cmd_area3_ff),
    .o_cmd_ok       (cmd_ok),
    .o_rdata_strobe (rdata_strobe)
  );

  // Bus slave: address capture and read data register.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h0;
      hrdata_ff  <= 32'h0;
    end else begin
      wr_pend_ff <= wr_req;
      if (wr_req) begin
        wr_addr_ff <= i_haddr;
      end
      if (rd_req) begin
        hrdata_ff <= nxt_hrdata;
      end
    end
  end

  // Register writes; only the writable fields store, the rest is dropped.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      area2_lat_ff <= SDTC_LAT_RST;
      area3_lat_ff <= SDTC_LAT_RST;
      rp_ff        <= SDTC_RP_RST;
      rcd_ff       <= SDTC_RCD_RST;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == SDTC_OFS_AREA2) begin
        area2_lat_ff <= i_hwdata[SDTC_LAT_LSB +: 2];
      end
      if (wr_addr_ff == SDTC_OFS_AREA3) begin
        area3_lat_ff <= i_hwdata[SDTC_LAT_LSB +: 2];
        rp_ff        <= i_hwdata[SDTC_RP_LSB +: 2];
        rcd_ff       <= i_hwdata[SDTC_RCD_LSB +: 2];
      end
    end
  end

  // Command port: a write presents one command for one cycle.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cmd_ff         <= 2'h0;
      cmd_area3_ff   <= 1'b0;
      cmd_ok_ff      <= 1'b0;
      rstrobe_ff     <= 1'b0;
      refused_cnt_ff <= 8'h0;
    end else begin
      if (wr_pend_ff && (wr_addr_ff == SDTC_OFS_CMD)) begin
        cmd_ff       <= i_hwdata[1:0];
        cmd_area3_ff <= i_hwdata[4];
      end else begin
        cmd_ff <= 2'h0;
      end
      if (cmd_now != SDTC_CMD_NONE) begin
        cmd_ok_ff <= cmd_ok;
        if (!cmd_ok) begin
          refused_cnt_ff <= refused_cnt_ff + 8'h1;
        end
      end
      if (rdata_strobe) begin
        rstrobe_ff <= ~rstrobe_ff;
      end
    end
  end

  // Registered copies of configuration for the output pins.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_lat2_ff <= SDTC_LAT_RST;
      o_lat3_ff <= SDTC_LAT_RST;
      o_rp_ff   <= SDTC_RP_RST;
      o_rcd_ff  <= SDTC_RCD_RST;
    end else begin
      o_lat2_ff <= area2_lat_ff;
      o_lat3_ff <= area3_lat_ff;
      o_rp_ff   <= rp_ff;
      o_rcd_ff  <= rcd_ff;
    end
  end

  assign o_hrdata                = hrdata_ff;
  assign o_hreadyout             = 1'b1;
  assign o_hresp                 = 1'b0;
  assign o_area2_latency         = o_lat2_ff;
  assign o_area3_latency         = o_lat3_ff;
  assign o_precharge_to_activate = o_rp_ff;
  assign o_activate_to_access    = o_rcd_ff;

endmodule

// file: logic/sdtc_pkg.sv
package sdtc_pkg;

  // Register byte offsets on the AHB-Lite slave.
  localparam logic [11:0] SDTC_OFS_AREA2   = 12'h000;
  localparam logic [11:0] SDTC_OFS_AREA3   = 12'h004;
  localparam logic [11:0] SDTC_OFS_CMD     = 12'h008;
  localparam logic [11:0] SDTC_OFS_STATUS  = 12'h00c;

  // Field positions.
  localparam int SDTC_LAT_LSB   = 7;
  localparam int SDTC_RCD_LSB   = 10;
  localparam int SDTC_RP_LSB    = 13;
  localparam int SDTC_FIXED_ONE = 10;

  // Reset values of the fields.
  localparam logic [1:0] SDTC_LAT_RST = 2'h2;
  localparam logic [1:0] SDTC_RP_RST  = 2'h0;
  localparam logic [1:0] SDTC_RCD_RST = 2'h0;

  // Latency codes that software may program.
  localparam logic [1:0] SDTC_LAT_2 = 2'h1;
  localparam logic [1:0] SDTC_LAT_3 = 2'h2;

  // Command codes of the command-port register.
  typedef enum logic [1:0] {
    SDTC_CMD_NONE,
    SDTC_CMD_ACT,
    SDTC_CMD_ACCESS,
    SDTC_CMD_PRE
  } sdtc_cmd_t;

endpackage

// file: logic/sdtc_cfg_if.sv
`timescale 1ns/100ps
interface sdtc_cfg_if;
  logic [1:0] area2_latency;
  logic [1:0] area3_latency;
  logic [1:0] precharge_to_activate;
  logic [1:0] activate_to_access;

  modport src (output area2_latency, output area3_latency, output precharge_to_activate, output activate_to_access);
  modport snk (input area2_latency, input area3_latency, input precharge_to_activate, input activate_to_access);
endinterface

// file: logic/sdtc_spacing.sv
`timescale 1ns/100ps
module sdtc_spacing
  import sdtc_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  sdtc_cfg_if.snk         cfg,
  input  wire sdtc_cmd_t  i_cmd,
  input  wire logic       i_area3,
  output logic            o_cmd_ok,
  output logic            o_rdata_strobe
);

  logic [2:0] rp_cnt_ff;
  logic [2:0] rcd_cnt_ff;
  logic [3:0] lat_pipe_ff;
  logic [1:0] lat_code;
  logic [2:0] nxt_rp_cnt;
  logic [2:0] nxt_rcd_cnt;
  logic       is_act;
  logic       is_acc;
  logic       is_pre;

  assign is_act = (i_cmd == SDTC_CMD_ACT);
  assign is_acc = (i_cmd == SDTC_CMD_ACCESS);
  assign is_pre = (i_cmd == SDTC_CMD_PRE);

  // An activate or access is allowed only when its spacing counter has run out; a precharge is always allowed.
  assign o_cmd_ok = is_act ? (rp_cnt_ff == 3'h0) :
                    is_acc ? (rcd_cnt_ff == 3'h0) : 1'b1;

  // Spacing loads the code, so the next command may follow code+1 cycles later; the shared fields serve both areas.
  assign nxt_rp_cnt  = (is_pre && o_cmd_ok) ? {1'b0, cfg.precharge_to_activate} :
                       (rp_cnt_ff != 3'h0) ? rp_cnt_ff - 3'h1 : 3'h0;
  assign nxt_rcd_cnt = (is_act && o_cmd_ok) ? {1'b0, cfg.activate_to_access} :
                       (rcd_cnt_ff != 3'h0) ? rcd_cnt_ff - 3'h1 : 3'h0;

  // The accessed area picks its own read latency.
  assign lat_code = i_area3 ? cfg.area3_latency : cfg.area2_latency;

  // Read data strobe fires exactly latency cycles after the access command.
  assign o_rdata_strobe = lat_pipe_ff[0];

  // Counters and latency shift line.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rp_cnt_ff   <= 3'h0;
      rcd_cnt_ff  <= 3'h0;
      lat_pipe_ff <= 4'h0;
    end else begin
      rp_cnt_ff   <= nxt_rp_cnt;
      rcd_cnt_ff  <= nxt_rcd_cnt;
      lat_pipe_ff <= {1'b0, lat_pipe_ff[3:1]};
      if (is_acc && o_cmd_ok) begin
        if (lat_code == SDTC_LAT_2) begin
          lat_pipe_ff[1] <= 1'b1;
        end else begin
          lat_pipe_ff[2] <= 1'b1;
        end
      end
    end
  end

endmodule

// file: verification/sdtc_top_props.sv
`timescale 1ns/100ps
module sdtc_top_props
  import sdtc_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic        i_hsel,
  input wire logic [11:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic [1:0]  o_area2_latency,
  input wire logic [1:0]  o_area3_latency,
  input wire logic [1:0]  o_precharge_to_activate,
  input wire logic [1:0]  o_activate_to_access
);
  // Accepted transfers to the two timing registers.
  wire logic tk = i_hsel & i_hready & i_htrans[1];
  wire logic a2 = tk & (i_haddr == SDTC_OFS_AREA2);
  wire logic a3 = tk & (i_haddr == SDTC_OFS_AREA3);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // A written field reaches its pin three edges after the address phase.
  a_lat2_pin: assert property (a2 && i_hwrite |-> ##3 o_area2_latency == $past(i_hwdata[8:7], 2))
    else $error("area2 latency pin");
  a_lat3_pin: assert property (a3 && i_hwrite |-> ##3 o_area3_latency == $past(i_hwdata[8:7], 2))
    else $error("area3 latency pin");
  a_rp_pin: assert property (a3 && i_hwrite |-> ##3 o_precharge_to_activate == $past(i_hwdata[14:13], 2))
    else $error("rp pin");
  a_rcd_pin: assert property (a3 && i_hwrite |-> ##3 o_activate_to_access == $past(i_hwdata[11:10], 2))
    else $error("rcd pin");
  a_lat2_hold: assert property (!$past(a2 && i_hwrite, 3) |-> $stable(o_area2_latency))
    else $error("area2 pin moved");
  // Reserved bits read back fixed.
  a_rsvd2_read: assert property (a2 && !i_hwrite |=> (o_hrdata & 32'hffff_fe7f) == 32'h0000_0400)
    else $error("area2 reserved");
  a_rsvd3_read: assert property (a3 && !i_hwrite |=> (o_hrdata & 32'hffff_9200) == 32'h0000_0000)
    else $error("area3 reserved");
  a_zero_wait: assert property (tk |=> o_hreadyout)
    else $error("wait state");
  c_wr2: cover property (a2 && i_hwrite);
  c_wr3: cover property (a3 && i_hwrite);
  c_rd3: cover property (a3 && !i_hwrite);
endmodule

bind sdtc_top sdtc_top_props sdtc_top_props_inst (.*);

// file: verification/sdtc_sdram_model.sv
`timescale 1ns/100ps
module sdtc_sdram_model (
  input  wire logic [7:0] i_cfg,
  output int              o_cas,
  output int              o_rp
);
  // Read data appears this many cycles after a read command.
  assign o_cas = (i_cfg[5:4] == 2'h1) ? 2 : 3;
  // The memory needs this gap from precharge to the next activate.
  assign o_rp = 32'(i_cfg[3:2]) + 1;
endmodule

// file: verification/test_sdtc_top.sv
`timescale 1ns/100ps
module test_sdtc_top import sdtc_pkg::*;;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwr = 1'b0;
  logic        hrdy;
  logic [1:0]  htr = 2'h0;
  logic [11:0] ha = 12'h000;
  logic [31:0] hwd = 32'h0;
  logic [31:0] hrd;
  logic [31:0] rd;
  logic [7:0]  pins;
  int          failures = 0;
  int          checks = 0;
  int          nref = 0;
  int          cas;
  int          rp;

  sdtc_top sdtc_top_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(ha), .i_htrans(htr),
    .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(hrdy), .o_hrdata(hrd), .o_hreadyout(hrdy),
    .o_hresp(), .o_area2_latency(pins[7:6]), .o_area3_latency(pins[5:4]),
    .o_precharge_to_activate(pins[3:2]), .o_activate_to_access(pins[1:0]));
  sdtc_sdram_model sdtc_sdram_model_inst (.i_cfg(pins), .o_cas(cas), .o_rp(rp));

  // Clock at 200 MHz.
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask

  // One single transfer; read data lands in rd.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    ha <= a;
    hwr <= w;
    htr <= 2'h2;
    do @(posedge clk); while (hrdy !== 1'b1);
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrd;
  endtask

  task automatic t_reset;
    bus(1'b0, SDTC_OFS_AREA2, 32'h0);
    chk("area2", 32'h0000_0500, rd);
    bus(1'b0, SDTC_OFS_AREA3, 32'h0);
    chk("area3", 32'h0000_0100, rd & 32'hffff_ff80);
    chk("pins", 32'h0000_00a0, {24'h0, pins});
    bus(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("reset test done");
  endtask

  task automatic t_fields;
    bus(1'b1, SDTC_OFS_AREA2, 32'h0000_0480);
    bus(1'b1, SDTC_OFS_AREA3, 32'h0000_6c80);
    bus(1'b0, SDTC_OFS_AREA2, 32'h0);
    chk("area2 fields", 32'h0000_0480, rd);
    bus(1'b0, SDTC_OFS_AREA3, 32'h0);
    chk("area3 fields", 32'h0000_6c80, rd);
    chk("pins fields", 32'h0000_005f, {24'h0, pins});
    chk("model cas", 32'h2, cas);
    chk("model rp", 32'h4, rp);
    $display("field test done");
  endtask

  // Commands sit three cycles apart, so code 2 passes and code 3 is refused.
  task automatic t_spacing;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      bus(1'b1, SDTC_OFS_AREA3, {17'h0, c, 1'b0, c, 3'h2, 7'h0});
      bus(1'b1, SDTC_OFS_CMD, {30'h0, SDTC_CMD_PRE});
      bus(1'b1, SDTC_OFS_CMD, {27'h0, c[0], 2'h0, SDTC_CMD_ACT});
      bus(1'b0, SDTC_OFS_STATUS, 32'h0);
      chk("act gap", {31'h0, c != 2'h3}, {31'h0, rd[1]});
      bus(1'b1, SDTC_OFS_CMD, {30'h0, SDTC_CMD_ACT});
      bus(1'b1, SDTC_OFS_CMD, {27'h0, ~c[0], 2'h0, SDTC_CMD_ACCESS});
      bus(1'b0, SDTC_OFS_STATUS, 32'h0);
      nref += (c == 2'h3) ? 2 : 0;
      chk("access gap", {31'h0, c != 2'h3}, {31'h0, rd[1]});
      chk("refused", 32'(nref), {24'h0, rd[9:2]});
    end
    // Three accepted accesses toggle the capture flag an odd number of times.
    bus(1'b0, SDTC_OFS_STATUS, 32'h0);
    chk("strobe", 32'h1, {31'h0, rd[0]});
    $display("spacing test done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence after a 16-cycle reset.
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_spacing();
    report_and_stop();
  end

  // Watchdog well beyond the 124 or so cycles the tests need.
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
endmodule
